// ===== common/wdt_map.svh
// register offsets, reset values and timing counts of the watchdog block
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

`define WDT_OFF_CTRL      4'h0
`define WDT_OFF_STAT      4'h1
`define WDT_OFF_MASK      4'h2

`define WDT_CTRL_POR_VAL  8'h80
`define WDT_EV_W          2
`define WDT_EV_TIMEOUT    0
`define WDT_EV_ARMED      1

`define WDT_CNT_W         24
`define WDT_RST_WAIT_CYC  10'h200
`define WDT_START_CYC     2'h2

`endif

// ===== common/wdt_pkg.sv
// types shared by the watchdog supervisor
package wdt_pkg;

  typedef logic [7:0] wdt_byte_t;

  // supervisor_control_register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       por;
    logic       irq_en;
    logic [1:0] ivl;
    logic       flag;
    logic       cause;
    logic       rst_en;
    logic       restart;
  } wdt_ctrl_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    wdt_byte_t  data;
  } wdt_bus_t;

  typedef enum logic [3:0] {
    ST_OFF   = 4'b0001,
    ST_START = 4'b0010,
    ST_COUNT = 4'b0100,
    ST_ARMED = 4'b1000
  } wdt_state_t;

endpackage

// ===== src/wdt_top.sv
// watchdog supervisor with interval timer, reset countdown and register port
// Functional notes
// - both enables low stops and gates watchdog
// - disabled watchdog holds both counters cleared
// - counting starts one to three cycles after enable
// - divider chain; interval select picks timeout
// - writing restart bit clears interval count
// - timeout always sets the timeout flag
// - interrupt needs flag, enable, global, mask, idle
// - device reset only with reset enable set
// - after timeout count 512 more cycles
// - window expiry resets; restart or flag clear cancels
// - watchdog reset sets cause flag until cleared
// - interrupt and reset functions act independently
// - reset without interrupt enable raises no request
// - every reset clears interval, flag, restart bits
// - interval change restarts count unless countdown runs
// - power-on flag set by power-on reset or by a control write of 1
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_top #(
  parameter int IVL_EXP0 = 12,
  parameter int IVL_EXP1 = 15,
  parameter int IVL_EXP2 = 18,
  parameter int IVL_EXP3 = 21
) (
  input  wire logic             CLK,               // system clock
  input  wire logic             RST_B,             // power-on reset, low
  input  wire logic             OTHER_RST,         // other reset pulse
  input  wire logic [3:0]       ADDR,              // register address
  input  wire logic [7:0]       WDATA,             // write data
  input  wire logic             WR,                // write strobe
  input  wire logic             RD,                // read strobe
  output wdt_pkg::wdt_byte_t    RDATA,             // read data
  input  wire logic             GLOBAL_IRQ_ENABLE, // cpu global enable
  input  wire logic             SYSTEM_IRQ_MASK,   // system irq mask
  input  wire logic             IRQ_IN_SERVICE,    // irq being serviced
  output logic                  WDT_IRQ_REQ,       // gated timeout request
  output logic                  DEV_RESET_REQ,     // device reset pulse
  output logic                  IRQ                // masked status level
);
  import wdt_pkg::*;

  logic [1:0]              rst_sync;
  logic                    rst_n;
  wdt_bus_t                bus;
  wdt_ctrl_t               ctrl;
  wdt_ctrl_t               wctrl;
  wdt_ctrl_t               next_ctrl;
  wdt_state_t              state;
  wdt_state_t              next_state;
  logic [`WDT_CNT_W-1:0]   div_cnt;
  logic [`WDT_CNT_W-1:0]   next_div_cnt;
  logic [9:0]              rst_cnt;
  logic [9:0]              next_rst_cnt;
  logic [1:0]              dly;
  logic [1:0]              next_dly;
  logic [`WDT_EV_W-1:0]    stat;
  logic [`WDT_EV_W-1:0]    mask;
  logic [`WDT_EV_W-1:0]    ev;
  logic [`WDT_EV_W-1:0]    next_stat;
  wdt_byte_t               next_rdata;

  wire                     wr_ctrl;
  wire                     wr_mask;
  wire                     rd_stat;
  wire                     enabled;
  wire                     restart;
  wire                     ivl_change;
  wire                     limit_hit;
  wire                     timeout;
  wire                     cancel;
  wire                     wd_fire;
  wire                     sys_rst;
  wire                     irq_gate;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [`WDT_CNT_W-1:0] ivl_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    ivl_limit = (`WDT_CNT_W'(1) << IVL_EXP0) - `WDT_CNT_W'(1);
      2'h1:    ivl_limit = (`WDT_CNT_W'(1) << IVL_EXP1) - `WDT_CNT_W'(1);
      2'h2:    ivl_limit = (`WDT_CNT_W'(1) << IVL_EXP2) - `WDT_CNT_W'(1);
      default: ivl_limit = (`WDT_CNT_W'(1) << IVL_EXP3) - `WDT_CNT_W'(1);
    endcase
  endfunction

  // reset release through two flops
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign bus = '{wr: WR, rd: RD, addr: ADDR, data: WDATA};
  assign wctrl = wdt_ctrl_t'(bus.data);

  assign wr_ctrl    = bus.wr && hit(bus.addr, `WDT_OFF_CTRL);
  assign wr_mask    = bus.wr && hit(bus.addr, `WDT_OFF_MASK);
  assign rd_stat    = bus.rd && hit(bus.addr, `WDT_OFF_STAT);
  assign enabled    = ctrl.irq_en || ctrl.rst_en;
  assign restart    = wr_ctrl && wctrl.restart;
  assign ivl_change = wr_ctrl && (wctrl.ivl != ctrl.ivl);
  assign limit_hit  = (div_cnt == ivl_limit(ctrl.ivl));
  // restart in the same cycle as the terminal count wins
  assign timeout    = (state == ST_COUNT) && enabled && limit_hit &&
                      !restart && !ivl_change;
  assign cancel     = restart || !ctrl.flag || !ctrl.rst_en;
  assign wd_fire    = (state == ST_ARMED) && ctrl.rst_en && !cancel &&
                      (rst_cnt == `WDT_RST_WAIT_CYC - 10'h1);
  assign sys_rst    = wd_fire || OTHER_RST;
  assign irq_gate   = ctrl.flag && ctrl.irq_en && GLOBAL_IRQ_ENABLE &&
                      SYSTEM_IRQ_MASK && !IRQ_IN_SERVICE;

  // watchdog sequencer
  always_comb begin
    next_state   = state;
    next_div_cnt = div_cnt;
    next_rst_cnt = rst_cnt;
    next_dly     = dly;
    case (state)
      ST_OFF: begin
        next_div_cnt = '0;
        next_rst_cnt = '0;
        next_dly     = 2'h0;
        if (enabled) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        next_dly = dly + 2'h1;
        if (dly == `WDT_START_CYC - 2'h1) begin
          next_state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (restart || ivl_change) begin
          next_div_cnt = '0;
        end else if (timeout) begin
          next_div_cnt = '0;
          next_rst_cnt = '0;
          if (ctrl.rst_en) begin
            next_state = ST_ARMED;
          end
        end else begin
          next_div_cnt = div_cnt + `WDT_CNT_W'(1);
        end
      end
      ST_ARMED: begin
        // interval changes are ignored while the countdown runs
        if (cancel) begin
          next_state   = ST_COUNT;
          next_div_cnt = '0;
          next_rst_cnt = '0;
        end else begin
          next_rst_cnt = rst_cnt + 10'h1;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    if (!enabled || sys_rst) begin
      next_state   = ST_OFF;
      next_div_cnt = '0;
      next_rst_cnt = '0;
      next_dly     = 2'h0;
    end
  end

  // control register update
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl.por    = wctrl.por;
      next_ctrl.irq_en = wctrl.irq_en;
      next_ctrl.ivl    = wctrl.ivl;
      next_ctrl.flag   = wctrl.flag;
      next_ctrl.cause  = wctrl.cause;
      next_ctrl.rst_en = wctrl.rst_en;
    end
    next_ctrl.restart = 1'b0;
    if (timeout) begin
      next_ctrl.flag = 1'b1;
    end
    if (wd_fire) begin
      next_ctrl.cause = 1'b1;
    end
    if (sys_rst) begin
      next_ctrl.ivl  = 2'h0;
      next_ctrl.flag = 1'b0;
    end
  end

  assign ev = {`WDT_EV_W{1'b0}} |
              (`WDT_EV_W'(timeout) << `WDT_EV_TIMEOUT) |
              (`WDT_EV_W'(timeout && ctrl.rst_en) << `WDT_EV_ARMED);
  // a read clears the status, but an event in that cycle survives
  assign next_stat = (rd_stat ? {`WDT_EV_W{1'b0}} : stat) | ev;

  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `WDT_OFF_CTRL: next_rdata = wdt_byte_t'(ctrl);
        `WDT_OFF_STAT: next_rdata = 8'(stat);
        `WDT_OFF_MASK: next_rdata = 8'(mask);
        default:       next_rdata = 8'h00;
      endcase
    end
  end

  // the power-on flag is set by the power-on reset and by a control write of 1
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= wdt_ctrl_t'(`WDT_CTRL_POR_VAL);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state   <= ST_OFF;
      div_cnt <= '0;
      rst_cnt <= 10'h0;
      dly     <= 2'h0;
    end else begin
      state   <= next_state;
      div_cnt <= next_div_cnt;
      rst_cnt <= next_rst_cnt;
      dly     <= next_dly;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      stat <= '0;
      mask <= '0;
    end else begin
      stat <= next_stat;
      mask <= wr_mask ? bus.data[`WDT_EV_W-1:0] : mask;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA         <= 8'h00;
      WDT_IRQ_REQ   <= 1'b0;
      DEV_RESET_REQ <= 1'b0;
      IRQ           <= 1'b0;
    end else begin
      RDATA         <= next_rdata;
      WDT_IRQ_REQ   <= irq_gate;
      DEV_RESET_REQ <= wd_fire;
      IRQ           <= |(next_stat & mask);
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!rst_n);

  sequence s_off_then_start;
    (state == ST_OFF) ##1 (state == ST_START && enabled && !sys_rst)[*2];
  endsequence

  sequence s_armed_entry;
    (state == ST_ARMED) && (rst_cnt == 10'h0);
  endsequence

  sequence s_window_end;
    DEV_RESET_REQ || (state != ST_ARMED);
  endsequence

  a_off_clears: assert property (
    !enabled |=> (state == ST_OFF) && (div_cnt == '0) && (rst_cnt == 10'h0))
    else $error("disabled watchdog not stopped and cleared");

  a_start_delay: assert property (
    s_off_then_start |=> (state == ST_COUNT))
    else $error("counting did not start after two cycles");

  a_restart_clear: assert property (
    (state == ST_COUNT) && restart && enabled && !sys_rst |=> div_cnt == '0)
    else $error("restart did not clear the interval count");

  a_restart_reads0: assert property (
    bus.rd && hit(bus.addr, `WDT_OFF_CTRL) |=> RDATA[0] == 1'b0)
    else $error("restart bit did not read back as zero");

  a_timeout_flag: assert property (
    (state == ST_COUNT) && enabled && limit_hit && !restart &&
    !wr_ctrl && !sys_rst |=> ctrl.flag)
    else $error("timeout did not set the flag");

  a_irq_off_gate: assert property (
    !ctrl.irq_en || IRQ_IN_SERVICE || !GLOBAL_IRQ_ENABLE ||
    !SYSTEM_IRQ_MASK |=> !WDT_IRQ_REQ)
    else $error("interrupt request raised while gated off");

  a_flag_sticky: assert property (
    ctrl.flag && !wr_ctrl && !sys_rst |=> ctrl.flag)
    else $error("timeout flag cleared without a write");

  a_reset_needs_en: assert property (
    DEV_RESET_REQ |-> $past(ctrl.rst_en))
    else $error("device reset without reset enable");

  a_reset_window: assert property (
    DEV_RESET_REQ |-> $past(state) == ST_ARMED && $past(rst_cnt) == 10'h1FF)
    else $error("device reset not at end of 512 cycles");

  a_window_bound: assert property (
    s_armed_entry |-> ##[1:520] s_window_end)
    else $error("reset window ran past 512 cycles");

  a_cancel_armed: assert property (
    (state == ST_ARMED) && (restart || !ctrl.flag) && enabled &&
    !sys_rst |=> state == ST_COUNT)
    else $error("restart or flag clear did not cancel reset");

  a_cause_set: assert property (
    DEV_RESET_REQ |-> ctrl.cause && !ctrl.flag && ctrl.ivl == 2'h0)
    else $error("watchdog reset did not record its cause");

  a_irq_only_noarm: assert property (
    (state == ST_COUNT) && timeout && !ctrl.rst_en && !sys_rst
    |=> state == ST_COUNT)
    else $error("interrupt-only timeout armed a reset");

  a_sys_rst_clear: assert property (
    OTHER_RST |=> ctrl.ivl == 2'h0 && !ctrl.flag && state == ST_OFF)
    else $error("reset did not clear interval and flag");

  a_ivl_change: assert property (
    (state == ST_COUNT) && ivl_change && enabled && !sys_rst
    |=> div_cnt == '0)
    else $error("interval change did not restart count");

  a_por_kept: assert property (
    OTHER_RST && !wr_ctrl |=> ctrl.por == $past(ctrl.por))
    else $error("power-on flag changed by another reset");

endmodule

// ===== dv/wdt_top_tb.sv
// self-checking testbench for the watchdog supervisor
`timescale 1ns/1ps
module wdt_top_tb;
  import wdt_pkg::*;
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } wdt_row_t;
  localparam int EXPS [4] = '{3, 4, 5, 6};
  logic       clk;
  logic       rst_b;
  logic       other_rst;
  logic       wr;
  logic       rd;
  logic       gie;
  logic       msk;
  logic       irq_in_service;
  logic [3:0] addr;
  logic [7:0] wdata;
  wdt_byte_t  rdata;
  logic       irq_req;
  logic       dev_rst;
  logic       irq;
  int         err_count = 0;
  int         tests_run = 0;
  int         n_rst = 0;
  int         n_req = 0;
  int         n;
  int         m;
  // restart strobe reads 0, upper mask bits read 0, unmapped ignored
  wdt_row_t   rows [4] = '{'{4'h0, 8'h31, 8'h30}, '{4'h2, 8'hFF, 8'h03},
                           '{4'h5, 8'hAA, 8'h00}, '{4'h0, 8'h00, 8'h00}};

  wdt_top #(.IVL_EXP0(3), .IVL_EXP1(4), .IVL_EXP2(5), .IVL_EXP3(6))
  wdt_top_inst (.CLK(clk), .RST_B(rst_b), .OTHER_RST(other_rst),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .GLOBAL_IRQ_ENABLE(gie), .SYSTEM_IRQ_MASK(msk), .IRQ_IN_SERVICE(irq_in_service),
    .WDT_IRQ_REQ(irq_req), .DEV_RESET_REQ(dev_rst), .IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (dev_rst === 1'b1) n_rst <= n_rst + 1;
    if (irq_req === 1'b1) n_req <= n_req + 1;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string s);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(s, rdata, e);
  endtask

  // counts edges until the chosen output is high; bounded
  task automatic wait_hi(input bit use_rst, input int lim, output int c);
    for (c = 1; c <= lim; c++) begin
      @(posedge clk);
      #1;
      if ((use_rst ? dev_rst : irq_req) === 1'b1) return;
    end
    err_count++;
    $display("[ERR] wait_hi expected 1 seen 0");
    complete_run();
  endtask

  initial begin
    {rst_b, other_rst, wr, rd, irq_in_service, addr, wdata} = '0;
    {gie, msk} = 2'b11;
    do_reset();
    rdc(4'h0, 8'h80, "ctrl_reset");
    rdc(4'h1, 8'h00, "stat_reset");
    rdc(4'h2, 8'h00, "mask_reset");
    @(posedge clk);
    #1 chk("rdata_idle", rdata, 8'h00);
    $display("test reset_values done");
    foreach (rows[i]) begin
      wreg(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e, "reg_row");
    end
    $display("test reg_table done");
    for (int s = 0; s < 4; s++) begin
      m = n_rst;
      wreg(4'h0, 8'(8'h40 | (s << 4)));
      wait_hi(1'b0, 200, n);
      chk("ivl_delay", 8'(n >= 2 ** EXPS[s] + 2 && n <= 2 ** EXPS[s] + 6),
          8'h01);
      rdc(4'h0, 8'(8'h48 | (s << 4)), "flag_set");
      if (s == 3) begin
        chk("irq_level", irq, 1'b1);
        rdc(4'h1, 8'h01, "stat_ev");
        @(posedge clk);
        #1 chk("irq_clr", irq, 1'b0);
        irq_in_service <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("req_in_service", irq_req, 1'b0);
        irq_in_service <= 1'b0;
        msk <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("req_masked", irq_req, 1'b0);
        {gie, msk} <= 2'b01;
        repeat (2) @(posedge clk);
        #1 chk("req_no_gie", irq_req, 1'b0);
        gie <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("req_back", irq_req, 1'b1);
        other_rst <= 1'b1;
        @(posedge clk);
        other_rst <= 1'b0;
        rdc(4'h0, 8'h40, "ctrl_other_rst");
      end
      wreg(4'h0, 8'h00);
      chk("no_dev_rst", 8'(n_rst - m), 8'h00);
    end
    $display("test interval_sel done");
    rdc(4'h1, 8'h00, "stat_idle");
    m = n_req;
    wreg(4'h0, 8'h02);
    wait_hi(1'b1, 700, n);
    chk("rst_delay", 8'(n >= 520 && n <= 528), 8'h01);
    chk("no_req", 8'(n_req - m), 8'h00);
    rdc(4'h0, 8'h06, "cause_set");
    rdc(4'h1, 8'h03, "stat_armed");
    $display("test reset_function done");
    repeat (30) @(posedge clk);
    m = n_rst;
    wreg(4'h0, 8'h0F);
    repeat (10) @(posedge clk);
    wreg(4'h0, 8'h06);
    repeat (130) begin
      wreg(4'h0, 8'h07);
      repeat (3) @(posedge clk);
    end
    chk("cancelled", 8'(n_rst - m), 8'h00);
    wreg(4'h0, 8'h04);
    repeat (600) @(posedge clk);
    chk("rst_disabled", 8'(n_rst - m), 8'h00);
    rdc(4'h0, 8'h04, "cause_sticky");
    wreg(4'h0, 8'h00);
    rdc(4'h0, 8'h00, "cause_clear");
    $display("test cancel done");
    // interval changes every two cycles keep the count from expiring
    m = n_req;
    wreg(4'h0, 8'h40);
    repeat (20) begin
      wreg(4'h0, 8'h50);
      wreg(4'h0, 8'h40);
    end
    chk("ivl_restart", 8'(n_req - m), 8'h00);
    // 2**3 - 1 counts, one flag edge, one request edge
    wait_hi(1'b0, 40, n);
    chk("ivl_rerun", 8'(n), 8'h09);
    wreg(4'h0, 8'h00);
    $display("test ivl_change done");
    wreg(4'h0, 8'h72);
    do_reset();
    rdc(4'h0, 8'h80, "ctrl_rerst");
    $display("test mid_reset done");
    complete_run();
  end
endmodule
